// ### verilog/lcc_pkg.sv
// lcc_pkg: constants, register map and types of the logic cell block
// assumes a 32-bit APB slave port, registers in the low byte of each word
package lcc_pkg;
  localparam int NCELL = 4;  // logic cells
  localparam int NDIN  = 4;  // data inputs, also gates, per cell
  localparam int NSRC  = 8;  // selectable sources
  // register index inside one cell window, byte address is four times it
  localparam logic [3:0] RIX_CON  = 4'h0;
  localparam logic [3:0] RIX_POL  = 4'h1;
  localparam logic [3:0] RIX_SEL0 = 4'h2;  // input select 0..3 at 2..5
  localparam logic [3:0] RIX_GLS0 = 4'h6;  // gate select 0..3 at 6..9
  localparam logic [3:0] RIX_LAST = 4'h9;
  localparam logic [11:0] ADR_CELL_TOP = 12'h0FF;  // cells at 0x000 + 0x40*n
  localparam logic [11:0] ADR_MIRROR   = 12'h100;
  localparam logic [11:0] ADR_FLAG     = 12'h104;
  localparam logic [11:0] ADR_IE       = 12'h108;
  localparam logic [11:0] ADR_IRQ_CONTROL_REG   = 12'h10C;
  // field positions
  localparam int POL_OUT    = 7;
  localparam int IRQ_CONTROL_REG_GIE = 7;
  localparam int IRQ_CONTROL_REG_PIE = 6;
  localparam logic [2:0] SRC_FAST_OSC = 3'h7;  // source 7 is the fast oscillator
  // values after reset
  localparam logic [7:0] CON_RST    = 8'h00;
  localparam logic [3:0] FLAG_RST   = 4'h0;
  localparam logic [3:0] IE_RST     = 4'h0;
  localparam logic [1:0] IRQ_CONTROL_REG_RST = 2'h0;
  // combining functions of the four gates
  typedef enum logic [2:0] {
    LCC_ANDOR, LCC_ORXOR, LCC_AND4, LCC_SRLATCH,
    LCC_OR4, LCC_XOR4, LCC_DLATCH, LCC_NOR4
  } lcc_mode_t;
  // cell control register layout
  typedef struct packed {
    logic      en;    // cell_enable_bit
    logic      rsv;   // reads zero
    logic      out;   // cell_output_bit, read only
    logic      intp;  // rise_irq_enable
    logic      intn;  // fall_irq_enable
    lcc_mode_t mode;  // logic_function_field
  } lcc_con_t;
endpackage

// ### verilog/lcc_top.sv
// lcc_top: four configurable logic cells with edge interrupts behind APB
// assumes pclk 40 MHz, source pins asynchronous to pclk, an APB master that waits on pready
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module lcc_top (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // cell sources and results
  input  wire logic [lcc_pkg::NSRC-1:0]  cell_data_in,
  output logic      [lcc_pkg::NCELL-1:0] cell_out,
  output logic                           irq,
  output logic                           osc_keep_alive
);
  import lcc_pkg::*;

  logic [NSRC-1:0]  src_s1_q;                 // first sync stage
  logic [NSRC-1:0]  src_s2_q;                 // second sync stage
  lcc_con_t         con_q  [NCELL];           // cell_control_reg
  logic [7:0]       pol_q  [NCELL];           // polarity_reg
  logic [2:0]       sel_q  [NCELL][NDIN];     // input_select_reg 0..3
  logic [7:0]       gls_q  [NCELL][NDIN];     // gate_select_reg, [2] is gate_two_data_select
  logic [NCELL-1:0] out_q;                    // registered cell outputs
  logic [NCELL-1:0] prev_q;                   // previous output for edges
  logic [NCELL-1:0] lat_q;                    // latch state per cell
  logic [NCELL-1:0] lat_d;
  logic [NCELL-1:0] out_d;
  logic [NCELL-1:0] rise_w;
  logic [NCELL-1:0] fall_w;
  logic [NCELL-1:0] set_w;                    // qualified edge per cell
  logic [NCELL-1:0] clr_w;                    // software clear per cell
  logic [NCELL-1:0] osc_use_w;
  logic [NCELL-1:0] flag_q;                   // cell_irq_flag
  logic [NCELL-1:0] ie_q;                     // cell_irq_enable
  logic [1:0]       irq_control_reg_q;                 // global, peripheral gates
  logic [31:0]      prdata_q;
  logic [31:0]      rdata_d;
  logic             pready_q;
  logic             pslverr_q;
  logic             hit_d;
  logic             irq_q;
  logic             osc_q;
  logic             in_cell;                  // address inside cell windows
  logic [1:0]       cix;                      // addressed cell
  logic [3:0]       rix;                      // addressed register index
  logic [1:0]       six;                      // select or gate index
  logic             wr_w;                     // write taken this edge

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign cell_out       = out_q;
  assign irq            = irq_q;
  assign osc_keep_alive = osc_q;

  // address split, shared by read and write paths
  assign in_cell = (paddr <= ADR_CELL_TOP);
  assign cix     = paddr[7:6];
  assign rix     = paddr[5:2];
  assign six     = (rix < RIX_GLS0) ? 2'(rix - RIX_SEL0) : 2'(rix - RIX_GLS0);
  // a write lands only at the access edge that sees pready high
  assign wr_w    = psel & penable & pready_q & pwrite;

  // pins are asynchronous: two stages before any cell logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1_q <= '0;
      src_s2_q <= '0;
    end else begin
      src_s1_q <= cell_data_in;
      src_s2_q <= src_s1_q;
    end
  end

  // read mux and decode hit
  always_comb begin
    rdata_d = '0;
    hit_d   = 1'b1;
    if (in_cell && rix == RIX_CON) begin
      rdata_d[7:0] = con_q[cix];
      rdata_d[5]   = out_q[cix];                 // live output in place of stored bit
    end else if (in_cell && rix == RIX_POL) begin
      rdata_d[7:0] = pol_q[cix];
    end else if (in_cell && rix >= RIX_SEL0 && rix < RIX_GLS0) begin
      rdata_d[2:0] = sel_q[cix][six];
    end else if (in_cell && rix >= RIX_GLS0 && rix <= RIX_LAST) begin
      rdata_d[7:0] = gls_q[cix][six];
    end else if (paddr == ADR_MIRROR) begin
      rdata_d[NCELL-1:0] = out_q;                // one edge samples every cell
    end else if (paddr == ADR_FLAG) begin
      rdata_d[NCELL-1:0] = flag_q;
    end else if (paddr == ADR_IE) begin
      rdata_d[NCELL-1:0] = ie_q;
    end else if (paddr == ADR_IRQ_CONTROL_REG) begin
      rdata_d[7:6] = irq_control_reg_q;
    end else begin
      hit_d = 1'b0;                              // unmapped: error answer
    end
  end

  // apb answer: no wait state, ready and data staged in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit_d;
      if (psel && !penable) begin
        prdata_q <= pwrite ? '0 : rdata_d;       // mirror captured here, all cells at once
      end
    end
  end

  // control register: cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCELL; c++) begin
        con_q[c] <= lcc_con_t'(CON_RST);
      end
    end else if (wr_w && in_cell && rix == RIX_CON && hit_d) begin
      con_q[cix] <= lcc_con_t'({pwdata[7], 2'b00, pwdata[4:0]});
    end
  end

  // selections carry no reset so they survive it; unknown until first written
  always_ff @(posedge pclk) begin
    if (wr_w && in_cell && rix == RIX_POL) begin
      pol_q[cix] <= pwdata[7:0];
    end
    if (wr_w && in_cell && rix >= RIX_SEL0 && rix < RIX_GLS0) begin
      sel_q[cix][six] <= pwdata[2:0];
    end
    if (wr_w && in_cell && rix >= RIX_GLS0 && rix <= RIX_LAST) begin
      gls_q[cix][six] <= pwdata[7:0];
    end
  end

  // per cell datapath: selects, gates, function, polarity, edges
  for (genvar c = 0; c < NCELL; c++) begin : g_cell
    logic [NDIN-1:0] din;
    logic [7:0]      pv;                         // pair vector, true above inverted
    logic [NDIN-1:0] gt;
    logic            fn;
    for (genvar d = 0; d < NDIN; d++) begin : g_din
      assign din[d]       = src_s2_q[sel_q[c][d]];
      assign pv[2*d+1]    = din[d];
      assign pv[2*d]      = ~din[d];
      assign gt[d]        = (|(gls_q[c][d] & pv)) ^ pol_q[c][d];
    end
    logic [NDIN-1:0] osc_hit;                    // per select: enabled cell picks the oscillator
    for (genvar d = 0; d < NDIN; d++) begin : g_osc
      assign osc_hit[d] = con_q[c].en & (sel_q[c][d] == SRC_FAST_OSC);
    end
    // one driver per cell for the oscillator request
    assign osc_use_w[c] = |osc_hit;

    // combining function; latches are held in lat_q
    always_comb begin
      lat_d[c] = lat_q[c];
      fn       = 1'b0;
      unique case (con_q[c].mode)
        LCC_ANDOR:   fn = (gt[0] & gt[1]) | (gt[2] & gt[3]);
        LCC_ORXOR:   fn = (gt[0] | gt[1]) ^ (gt[2] | gt[3]);
        LCC_AND4:    fn = &gt;
        LCC_SRLATCH: begin
          lat_d[c] = (gt[0] | gt[1]) | (lat_q[c] & ~(gt[2] | gt[3]));  // set wins
          fn       = lat_d[c];
        end
        LCC_OR4:     fn = |gt;
        LCC_XOR4:    fn = ^gt;
        LCC_DLATCH: begin
          lat_d[c] = gt[0] ? gt[1] : lat_q[c];   // gate 0 opens, gate 1 is data
          fn       = lat_d[c];
        end
        LCC_NOR4:    fn = ~(|gt);
      endcase
      out_d[c] = con_q[c].en & (fn ^ pol_q[c][POL_OUT]);
    end

    // edge detectors against the registered copy
    assign rise_w[c] = out_q[c] & ~prev_q[c];
    assign fall_w[c] = ~out_q[c] & prev_q[c];
    assign set_w[c]  = (rise_w[c] & con_q[c].intp) | (fall_w[c] & con_q[c].intn);
    assign clr_w[c]  = wr_w & (paddr == ADR_FLAG) & pwdata[c];

    chk_rise_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      rise_w[c] && con_q[c].intp |=> flag_q[c]) else $error("rising edge lost");
    chk_flag_has_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(flag_q[c]) |-> $past(set_w[c])) else $error("flag set without enabled edge");
    chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      flag_q[c] && !clr_w[c] |=> flag_q[c]) else $error("flag dropped without clear");
    chk_set_beats_clr: assert property (@(posedge pclk) disable iff (!presetn)
      set_w[c] && clr_w[c] |=> flag_q[c]) else $error("clear beat a new edge");
    chk_disabled_low: assert property (@(posedge pclk) disable iff (!presetn)
      !con_q[c].en |=> !out_q[c]) else $error("disabled cell output high");
    chk_edge_once: assert property (@(posedge pclk) disable iff (!presetn)
      (rise_w[c] | fall_w[c]) == (out_q[c] != $past(out_q[c]))) else $error("edge not one per output change");
    chk_osc_keep: assert property (@(posedge pclk) disable iff (!presetn)
      osc_use_w[c] |=> osc_keep_alive) else $error("oscillator request missing");
  end

  // outputs, latches and edge history run on every edge, no cpu involvement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q  <= '0;
      prev_q <= '0;
      lat_q  <= '0;
    end else begin
      out_q  <= out_d;
      prev_q <= out_q;
      lat_q  <= lat_d;
    end
  end

  // sticky flags: hardware set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= FLAG_RST;
    end else begin
      flag_q <= (flag_q & ~clr_w) | set_w;
    end
  end

  // mask and global gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q     <= IE_RST;
      irq_control_reg_q <= IRQ_CONTROL_REG_RST;
    end else begin
      if (wr_w && paddr == ADR_IE) begin
        ie_q <= pwdata[NCELL-1:0];
      end
      if (wr_w && paddr == ADR_IRQ_CONTROL_REG) begin
        irq_control_reg_q <= pwdata[IRQ_CONTROL_REG_GIE:IRQ_CONTROL_REG_PIE];
      end
    end
  end

  // interrupt line and oscillator request, both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      irq_q <= irq_control_reg_q[1] & irq_control_reg_q[0] & (|(flag_q & ie_q));
      osc_q <= |osc_use_w;
    end
  end

  chk_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(irq_control_reg_q[1]) && $past(irq_control_reg_q[0]) && ($past(flag_q & ie_q) != '0))
    else $error("interrupt without all enables");
  chk_mirror_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == ADR_MIRROR |=> prdata[NCELL-1:0] == $past(out_q))
    else $error("mirror not a single snapshot");
endmodule

// ### tb/lcc_top_tb_top.sv
// lcc_top_tb_top: self-checking bench for the logic cell block
// assumes lcc_pkg and lcc_top compiled first; registers sit in the low byte
`timescale 1ns/1ps
module lcc_top_tb_top;
  import lcc_pkg::*;
  // apb side
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // cell side
  logic [7:0]  cell_data_in;
  logic [3:0]  cell_out;
  logic        irq, osc_keep_alive;
  // bench model state
  logic [3:0]  mo;        // expected cell outputs
  logic        st;        // expected latch state of cell 0
  logic [32:0] exp_q[$];  // notes {pslverr, prdata} per transfer
  string       nm_q[$];   // what each note checks
  logic [32:0] mon_e;
  string       mon_n;
  int          fails, checks_done;

  lcc_top i_lcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_data_in(cell_data_in), .cell_out(cell_out), .irq(irq), .osc_keep_alive(osc_keep_alive));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // monitor: every completed transfer retires the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected transfer", 32'h0, 32'h1);
      else begin
        mon_e = exp_q.pop_front();
        mon_n = nm_q.pop_front();
        chk(mon_n, mon_e[31:0], prdata);
        chk({mon_n, " error"}, {31'h0, mon_e[32]}, {31'h0, pslverr});
      end
    end
  end

  // one apb transfer; entered just after a rising edge, one idle cycle after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ex,
                     input logic er, input string nm);
    int k;
    exp_q.push_back({er, w ? 32'h0 : ex});  // writes read back zero
    nm_q.push_back(nm);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);  // pready sampled at the rising edge, request held until then
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0, "write");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0, ex, 1'b0, nm);
  endtask

  function automatic logic [11:0] ca(input int n, input int i);
    return 12'(n * 64 + i * 4);  // cell window of 0x40 bytes
  endfunction

  // disable first, then each input select with its gate select, polarity, enable last
  task automatic cfg(input int n, input logic [11:0] s, input logic [31:0] g, input logic [7:0] p,
                     input logic [7:0] c);
    int i;
    wr(ca(n, RIX_CON), 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(ca(n, RIX_SEL0 + i), {29'h0, s[3*i+:3]});
      wr(ca(n, RIX_GLS0 + i), {24'h0, g[8*i+:8]});
    end
    wr(ca(n, RIX_POL), {24'h0, p});
    wr(ca(n, RIX_CON), {24'h0, c});
  endtask

  // combining functions as the bench expects them
  function automatic logic fm(input int m, input logic [3:0] g, input logic s);
    case (m)
      0: return (g[0] & g[1]) | (g[2] & g[3]);
      1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      2: return &g;
      3: return (g[0] | g[1]) ? 1'b1 : ((g[2] | g[3]) ? 1'b0 : s);  // set wins
      4: return |g;
      5: return ^g;
      6: return g[0] ? g[1] : s;
      default: return ~|g;
    endcase
  endfunction

  // sync delay plus output register, then mirror and pin compared together
  task automatic see_out;
    repeat (5) @(posedge pclk);
    rd(ADR_MIRROR, {28'h0, mo}, "mirror");
    chk("cell_out", {28'h0, mo}, {28'h0, cell_out});
  endtask

  task automatic rst;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  initial begin
    int n, m, v;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    cell_data_in = '0; mo = '0; st = 1'b0; fails = 0; checks_done = 0;
    void'($urandom(21633));
    rst();
    // values after reset, unmapped place refused
    for (n = 0; n < 4; n++) rd(ca(n, RIX_CON), {24'h0, CON_RST}, "control");
    rd(ADR_FLAG, {28'h0, FLAG_RST}, "flag");
    rd(ADR_IE, {28'h0, IE_RST}, "irq enable");
    rd(ADR_IRQ_CONTROL_REG, 32'h0, "irq control");
    apb(1'b0, 12'h200, 32'h0, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, 12'h200, 32'hFF, 32'h0, 1'b1, "unmapped write");
    // every function on cell 0, gate d takes true input d from source d
    for (m = 0; m < 8; m++) begin
      cell_data_in <= 8'h03;  // defined latch state before enable
      cfg(0, {3'd3, 3'd2, 3'd1, 3'd0}, 32'h80200802, 8'h00, 8'h80 | 8'(m));
      st = fm(m, 4'h3, 1'b0);
      mo[0] = st;
      see_out();
      for (v = 0; v < 4; v++) begin
        cell_data_in <= 8'($urandom());
        @(posedge pclk);
        st = fm(m, cell_data_in[3:0], st);
        mo[0] = st;
        see_out();
      end
    end
    wr(ca(0, RIX_CON), 32'h0);
    mo = '0;
    // gate 2 of cell 1: bit 7 true input 3 from source 5, bit 0 inverted input 0 from source 4, output and gate 2 inversion
    for (m = 0; m < 8; m++) begin
      cell_data_in <= {2'b00, m[1:0], 4'h0};
      cfg(1, {3'd5, 3'd0, 3'd0, 3'd4}, 32'h00810000, {m[2], 4'h0, m[1] & m[0], 2'b00}, 8'h84);
      mo[1] = ((m[1] | ~m[0]) ^ (m[1] & m[0])) ^ m[2];
      see_out();
    end
    wr(ca(1, RIX_CON), 32'h0);
    mo = '0;
    // edge interrupts on cell 2, rise enabled only
    cell_data_in <= 8'h00;
    cfg(2, 12'h006, 32'h00000002, 8'h00, 8'h94);
    cell_data_in <= 8'h40;
    mo[2] = 1'b1;
    see_out();
    rd(ADR_FLAG, 32'h4, "flag on rise");
    wr(ADR_IE, 32'h4);
    wr(ADR_IRQ_CONTROL_REG, 32'h40);
    repeat (2) @(posedge pclk);
    chk("irq without global gate", 32'h0, {31'h0, irq});
    wr(ADR_IRQ_CONTROL_REG, 32'hC0);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    cell_data_in <= 8'h00;
    mo[2] = 1'b0;
    see_out();
    wr(ADR_FLAG, 32'h4);
    rd(ADR_FLAG, 32'h0, "flag after clear, fall not enabled");
    chk("irq after clear", 32'h0, {31'h0, irq});
    // fall enabled only
    cfg(2, 12'h006, 32'h00000002, 8'h00, 8'h8C);
    cell_data_in <= 8'h40;
    mo[2] = 1'b1;
    see_out();
    rd(ADR_FLAG, 32'h0, "flag on rise, rise off");
    cell_data_in <= 8'h00;
    mo[2] = 1'b0;
    see_out();
    rd(ADR_FLAG, 32'h4, "flag on fall");
    wr(ADR_IE, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADR_FLAG, 32'h0);
    rd(ADR_FLAG, 32'h4, "flag sticks");
    // a falling edge reaches the flag on the very edge of the clearing write
    cell_data_in <= 8'h40;
    mo[2] = 1'b1;
    see_out();
    cell_data_in <= 8'h00;
    mo[2] = 1'b0;
    repeat (2) @(posedge pclk);  // sync, output and edge stages meet the access edge
    wr(ADR_FLAG, 32'h4);
    rd(ADR_FLAG, 32'h4, "flag set during clear");
    // fast oscillator kept alive only for an enabled cell selecting it
    cfg(3, 12'h038, 32'h0, 8'h00, 8'h80);
    repeat (2) @(posedge pclk);
    chk("keep alive", 32'h1, {31'h0, osc_keep_alive});
    wr(ca(3, RIX_CON), 32'h0);
    repeat (2) @(posedge pclk);
    chk("keep alive off", 32'h0, {31'h0, osc_keep_alive});
    // reset in mid-run: control and flags clear, selections kept
    rst();
    rd(ca(2, RIX_CON), 32'h0, "control after reset");
    rd(ca(2, RIX_SEL0), 32'h6, "select kept");
    rd(ca(2, RIX_GLS0), 32'h2, "gate select kept");
    rd(ca(1, RIX_POL), 32'h84, "polarity kept");
    rd(ADR_FLAG, 32'h0, "flag after reset");
    tally_and_finish();
  end
endmodule
